// >>> verilog/otpfc_ctrl.sv
`timescale 1ns/10ps
module otpfc_ctrl import otpfc_pkg::*; #(
  parameter int STEP_CYC = OTPFC_STEP_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Fuse array (one-hot blow strobes, sensed levels)
  input wire logic [7:0] fuse_sense,
  output logic [7:0] fuse_blow,
  // Pins
  input wire logic bus_address_select,
  output logic [OTPFC_TAPS-1:0] tap_select,
  output logic validation_status_high,
  output logic validation_status_low,
  output logic irq
);

  // ---------------------------------------------------------------
  // Fuse indices: bit 0 test, bits 6:1 data, bit 7 lock
  // ---------------------------------------------------------------
  localparam int FUSE_TEST = 0;
  localparam int FUSE_DATA0 = 1;
  localparam int FUSE_LOCK = 7;
  localparam logic [2:0] LAST_DATA = 3'h5;
  localparam logic [OTPFC_TAPS-1:0] MID_TAP = {{(OTPFC_TAPS-1){1'b0}}, 1'b1} << OTPFC_MIDSCALE;
  // Power-on load sequence
  localparam logic [1:0] BOOT_WAIT = 2'h0;
  localparam logic [1:0] BOOT_LOAD = 2'h1;
  localparam logic [1:0] BOOT_DONE = 2'h2;

  function automatic logic [OTPFC_TAPS-1:0] tap_decode(input logic [5:0] code);
    tap_decode = '0;
    tap_decode[code] = 1'b1;
  endfunction

  logic [5:0] wiper_code_latch;
  logic [1:0] vstat;
  logic [1:0] boot;
  otpfc_state_t state;
  logic [15:0] div_cnt;
  logic step;
  logic [2:0] bit_idx;
  logic [OTPFC_EV_W-1:0] irq_stat;
  logic [OTPFC_EV_W-1:0] irq_en;
  logic [OTPFC_EV_W-1:0] ev;
  logic wr_en;
  logic rd_en;
  logic trig_wr;
  logic locked;
  logic busy;
  logic trig_go;
  logic [OTPFC_CODE_W-1:0] fuse_code;
  logic code_bad;
  logic test_bad;
  logic verify_bad;
  logic refuse_trig;
  logic [31:0] next_prdata;
  logic next_slverr;

  // Writes land only at the access edge, with pready high
  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && !penable && !pwrite;
  assign trig_wr = wr_en && paddr == OTPFC_CTRL_OFF && pwdata[OTPFC_TRIG_BIT];
  assign locked = fuse_sense[FUSE_LOCK];
  assign busy = state != OTPFC_IDLE && state != OTPFC_HALT;
  assign fuse_code = fuse_sense[FUSE_DATA0 +: OTPFC_CODE_W];
  // Trigger is taken only from an unlocked, idle, booted part
  assign trig_go = trig_wr && state == OTPFC_IDLE && boot == BOOT_DONE && !locked &&
    vstat == OTPFC_VAL_READY;
  assign code_bad = fuse_code != wiper_code_latch;
  assign test_bad = state == OTPFC_TEST && step && !fuse_sense[FUSE_TEST];
  assign verify_bad = state == OTPFC_VERIFY && step && code_bad;
  // Refusal also flags a retry after a halt, which the host must avoid
  assign refuse_trig = trig_wr && !trig_go;

  // ---------------------------------------------------------------
  // Power-on load of wiper
  // ---------------------------------------------------------------
  // Fuse sense is only trusted one cycle after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot <= BOOT_WAIT;
    end else if (boot != BOOT_DONE) begin
      boot <= boot + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wiper_code_latch <= OTPFC_MIDSCALE;
    end else if (boot == BOOT_LOAD) begin
      // Lock outranks the bus: a programmed part never drifts
      if (locked) begin
        wiper_code_latch <= fuse_code;
      end
    end else if (wr_en && paddr == OTPFC_WIPER_OFF && !busy && !locked) begin
      wiper_code_latch <= pwdata[OTPFC_CODE_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Midscale shows at once, before the boot load settles
      tap_select <= MID_TAP;
    end else begin
      tap_select <= tap_decode(wiper_code_latch);
    end
  end

  // ---------------------------------------------------------------
  // Programming step clock
  // ---------------------------------------------------------------
  // Divider runs only while sequencing, standing for the gated OTP clock
  // Limitation: a STEP_CYC of one gives a step every cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
      step <= 1'b0;
    end else if (!busy) begin
      div_cnt <= '0;
      step <= 1'b0;
    end else if (div_cnt == 16'(STEP_CYC - 1)) begin
      div_cnt <= '0;
      step <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 16'h1;
      step <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Fuse sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= OTPFC_IDLE;
      bit_idx <= '0;
    end else begin
      case (state)
        OTPFC_IDLE: begin
          if (trig_go) begin
            state <= OTPFC_TEST;
          end
        end
        OTPFC_TEST: begin
          // Sense settles one cycle after the pulse, inside the first step
          if (step) begin
            if (!fuse_sense[FUSE_TEST]) begin
              state <= OTPFC_HALT;
            end else begin
              state <= OTPFC_DATA;
              bit_idx <= '0;
            end
          end
        end
        OTPFC_DATA: begin
          if (step) begin
            if (bit_idx == LAST_DATA) begin
              state <= OTPFC_VERIFY;
            end else begin
              bit_idx <= bit_idx + 3'h1;
            end
          end
        end
        OTPFC_VERIFY: begin
          if (step) begin
            if (code_bad) begin
              state <= OTPFC_HALT;
            end else begin
              state <= OTPFC_LOCK;
            end
          end
        end
        OTPFC_LOCK: begin
          if (step) begin
            state <= OTPFC_HALT;
          end
        end
        // Halt is terminal until the next power-on
        OTPFC_HALT: state <= OTPFC_HALT;
        default: state <= OTPFC_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Fuse blow strobes
  // ---------------------------------------------------------------
  // Single-cycle pulses; a held strobe would keep stressing the cell
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_blow <= '0;
    end else begin
      fuse_blow <= '0;
      if (trig_go) begin
        fuse_blow[FUSE_TEST] <= 1'b1;
      end else if (state == OTPFC_DATA && step) begin
        // Only ones are blown; unblown fuse reads zero
        fuse_blow[FUSE_DATA0 + int'(bit_idx)] <= wiper_code_latch[bit_idx];
      end else if (state == OTPFC_VERIFY && step && !code_bad) begin
        fuse_blow[FUSE_LOCK] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Validation status
  // ---------------------------------------------------------------
  // Boot load and a live sequence never meet: trigger waits for boot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vstat <= OTPFC_VAL_READY;
    end else if (boot == BOOT_LOAD && locked) begin
      vstat <= OTPFC_VAL_OK;
    end else if (test_bad) begin
      vstat <= OTPFC_VAL_TESTFAIL;
    end else if (state == OTPFC_VERIFY && step) begin
      if (code_bad) begin
        vstat <= OTPFC_VAL_FATAL;
      end else begin
        vstat <= OTPFC_VAL_OK;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      validation_status_high <= 1'b0;
      validation_status_low <= 1'b0;
    end else begin
      validation_status_high <= vstat[1];
      validation_status_low <= vstat[0];
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  // Events are single-cycle strobes into sticky bits
  always_comb begin
    ev = '0;
    ev[OTPFC_EV_DONE] = state == OTPFC_LOCK && step;
    ev[OTPFC_EV_FAIL] = test_bad || verify_bad;
    ev[OTPFC_EV_REFUSED] = refuse_trig;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
    end else begin
      // Set wins over a clear in the same cycle
      if (wr_en && paddr == OTPFC_IRQ_CLR_OFF) begin
        irq_stat <= (irq_stat & ~pwdata[OTPFC_EV_W-1:0]) | ev;
      end else begin
        irq_stat <= irq_stat | ev;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en <= '0;
    end else if (wr_en && paddr == OTPFC_IRQ_EN_OFF) begin
      irq_en <= pwdata[OTPFC_EV_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      // Level, one cycle behind the sticky bits
      irq <= |(irq_stat & irq_en);
    end
  end

  // ---------------------------------------------------------------
  // APB slave: no wait states, read data registered in setup
  // ---------------------------------------------------------------
  always_comb begin
    next_prdata = '0;
    next_slverr = 1'b0;
    case (paddr)
      OTPFC_WIPER_OFF: next_prdata[OTPFC_CODE_W-1:0] = wiper_code_latch;
      OTPFC_CTRL_OFF: next_prdata = '0;
      OTPFC_STATUS_OFF: begin
        next_prdata[1:0] = vstat;
        next_prdata[OTPFC_BUSY_BIT] = busy;
        next_prdata[OTPFC_LOCK_BIT] = locked;
        // Strap pin read live; it never changes in use
        next_prdata[OTPFC_ADSEL_BIT] = bus_address_select;
      end
      OTPFC_IRQ_STAT_OFF: next_prdata[OTPFC_EV_W-1:0] = irq_stat;
      OTPFC_IRQ_EN_OFF: next_prdata[OTPFC_EV_W-1:0] = irq_en;
      OTPFC_IRQ_CLR_OFF: next_prdata = '0;
      OTPFC_TAP_OFF: next_prdata[OTPFC_CODE_W-1:0] = wiper_code_latch;
      default: next_slverr = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= next_slverr;
      // Read data then holds until the next transfer
      prdata <= rd_en ? next_prdata : 32'h0000_0000;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

// >>> verilog/otpfc_pkg.sv
package otpfc_pkg;

  // ---------------------------------------------------------------
  // Register map (byte offsets, APB, one word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] OTPFC_WIPER_OFF = 8'h00;
  localparam logic [7:0] OTPFC_CTRL_OFF = 8'h04;
  localparam logic [7:0] OTPFC_STATUS_OFF = 8'h08;
  localparam logic [7:0] OTPFC_IRQ_STAT_OFF = 8'h0C;
  localparam logic [7:0] OTPFC_IRQ_EN_OFF = 8'h10;
  localparam logic [7:0] OTPFC_IRQ_CLR_OFF = 8'h14;
  localparam logic [7:0] OTPFC_TAP_OFF = 8'h18;

  // ---------------------------------------------------------------
  // Fields and values
  // ---------------------------------------------------------------
  localparam int OTPFC_CODE_W = 6;
  localparam int OTPFC_TAPS = 64;
  localparam logic [5:0] OTPFC_MIDSCALE = 6'h20;
  localparam int OTPFC_TRIG_BIT = 0;
  localparam int OTPFC_BUSY_BIT = 2;
  localparam int OTPFC_LOCK_BIT = 3;
  localparam int OTPFC_ADSEL_BIT = 4;
  localparam logic [1:0] OTPFC_VAL_READY = 2'h0;
  localparam logic [1:0] OTPFC_VAL_TESTFAIL = 2'h1;
  localparam logic [1:0] OTPFC_VAL_FATAL = 2'h2;
  localparam logic [1:0] OTPFC_VAL_OK = 2'h3;

  // Interrupt event bits
  localparam int OTPFC_EV_DONE = 0;
  localparam int OTPFC_EV_FAIL = 1;
  localparam int OTPFC_EV_REFUSED = 2;
  localparam int OTPFC_EV_W = 3;

  // Programming clock divider: one fuse step per 1 us at 20 MHz
  localparam int OTPFC_CLK_HZ = 20000000;
  localparam int OTPFC_STEP_NS = 1000;
  localparam int OTPFC_STEP_CYC = OTPFC_STEP_NS / (1000000000 / OTPFC_CLK_HZ);

  typedef enum logic [2:0] {
    OTPFC_IDLE = 3'b000,
    OTPFC_TEST = 3'b001,
    OTPFC_DATA = 3'b010,
    OTPFC_VERIFY = 3'b011,
    OTPFC_LOCK = 3'b100,
    OTPFC_HALT = 3'b101
  } otpfc_state_t;

endpackage

// >>> testbench/otpfc_fuse_model.sv
`timescale 1ns/10ps
module otpfc_fuse_model (
  // Clock and unit swap
  input wire logic pclk,
  input wire logic fresh,
  // Fuse array
  input wire logic [7:0] fuse_blow,
  input wire logic [7:0] stuck,
  output logic [7:0] fuse_sense
);
  // ---------------------------------------------------------------
  // Fuse cells
  // ---------------------------------------------------------------
  // Cells survive device reset; only a fresh unit starts blank
  // A stuck cell ignores its blow pulse, as a weak fuse would
  always_ff @(posedge pclk) begin
    if (fresh) begin
      fuse_sense <= 8'h00;
    end else begin
      fuse_sense <= fuse_sense | (fuse_blow & ~stuck);
    end
  end
endmodule

// >>> testbench/otpfc_ctrl_sva.sv
`timescale 1ns/10ps
module otpfc_ctrl_sva import otpfc_pkg::*; #(
  parameter int STEP_CYC = OTPFC_STEP_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Fuses and pins
  input wire logic [7:0] fuse_sense,
  input wire logic [7:0] fuse_blow,
  input wire logic [OTPFC_TAPS-1:0] tap_select,
  input wire logic validation_status_high,
  input wire logic validation_status_low
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic seen_test;
  logic [1:0] vs;
  assign vs = {validation_status_high, validation_status_low};
  // Data fuses may only follow a test fuse attempt since reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_test <= 1'b0;
    end else if (fuse_blow[0]) begin
      seen_test <= 1'b1;
    end
  end
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("pready late");
  ready_one_cycle_a: assert property (pready |=> !pready) else $error("pready too long");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
  tap_one_hot_a: assert property ($onehot(tap_select)) else $error("tap not one-hot");
  blow_one_hot_a: assert property ($onehot0(fuse_blow)) else $error("two fuses at once");
  blow_pulse_a: assert property (|fuse_blow |=> fuse_blow == 8'h00) else $error("blow held");
  test_first_a: assert property (|fuse_blow[7:1] |-> seen_test) else $error("no test fuse");
  testfail_quiet_a: assert property (vs == 2'h1 |-> fuse_blow == 8'h00)
    else $error("blow after test fail");
  fatal_no_lock_a: assert property (vs == 2'h2 |-> !fuse_blow[7]) else $error("lock on fatal");
  lock_ok_a: assert property (fuse_blow[7] |-> ##[0:4] vs == 2'h3) else $error("no status 11");
  locked_quiet_a: assert property (fuse_sense[7] |-> fuse_blow == 8'h00)
    else $error("blow after lock");
endmodule
bind otpfc_ctrl otpfc_ctrl_sva #(.STEP_CYC(STEP_CYC)) u_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .fuse_sense(fuse_sense),
  .fuse_blow(fuse_blow), .tap_select(tap_select), .validation_status_high(validation_status_high),
  .validation_status_low(validation_status_low));

// >>> testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top import otpfc_pkg::*; ;
  logic pclk, presetn, psel, penable, pwrite, bus_address_select, fresh, irq, pready, pslverr;
  logic validation_status_high, validation_status_low;
  logic [7:0] paddr, fuse_sense, fuse_blow, stuck;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] tap_select;
  int errors, total_checks, nblow;
  otpfc_ctrl #(.STEP_CYC(2)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fuse_sense(fuse_sense), .fuse_blow(fuse_blow),
    .bus_address_select(bus_address_select), .tap_select(tap_select),
    .validation_status_high(validation_status_high),
    .validation_status_low(validation_status_low), .irq(irq));
  otpfc_fuse_model u_fuse (.pclk(pclk), .fresh(fresh), .fuse_blow(fuse_blow), .stuck(stuck),
    .fuse_sense(fuse_sense));
  // ---------------------------------------------------------------
  // Bus and check helpers
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    nblow <= fresh ? 0 : nblow + $countones(fuse_blow[6:1]);
  end
  task chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      $display("[FAIL] pready expected 1 seen %b", pready);
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task do_reset(input logic fr);
    presetn <= 1'b0;
    fresh <= fr;
    @(posedge pclk);
    fresh <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  // Program a new unit with the given stuck cells and wait for the end
  task run_unit(input logic [7:0] st, input logic [5:0] code);
    int k;
    stuck <= st;
    do_reset(1'b1);
    apb(1'b1, OTPFC_IRQ_EN_OFF, 32'h7);
    apb(1'b1, OTPFC_WIPER_OFF, {26'h0, code});
    apb(1'b1, OTPFC_CTRL_OFF, 32'h1);
    apb(1'b1, OTPFC_WIPER_OFF, 32'h11);
    k = 0;
    do begin
      apb(1'b0, OTPFC_STATUS_OFF, 32'h0);
      k++;
    end while (rd[OTPFC_BUSY_BIT] !== 1'b0 && k < 100);
    chk("busy", 0, rd[OTPFC_BUSY_BIT]);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_boot();
    chk("mid tap", 64'h1 << OTPFC_MIDSCALE, tap_select);
    chk("pins", 0, {validation_status_high, validation_status_low});
    apb(1'b0, OTPFC_STATUS_OFF, 32'h0);
    chk("status", 32'h10, rd);
    bus_address_select <= 1'b0;
    apb(1'b0, OTPFC_STATUS_OFF, 32'h0);
    chk("adsel", 32'h0, rd);
    apb(1'b0, 8'h1C, 32'h0);
    chk("slverr", 1, pslverr);
  endtask
  task t_adjust();
    logic [5:0] codes [4];
    codes = '{6'h00, 6'h3F, 6'h15, 6'h2A};
    foreach (codes[i]) begin
      apb(1'b1, OTPFC_WIPER_OFF, {26'h0, codes[i]});
      repeat (2) @(posedge pclk);
      chk("tap", 64'h1 << codes[i], tap_select);
      apb(1'b0, OTPFC_TAP_OFF, 32'h0);
      chk("tap code", codes[i], rd);
    end
  endtask
  task t_testfail();
    run_unit(8'h01, 6'h15);
    chk("pins", 2'h1, {validation_status_high, validation_status_low});
    chk("data blows", 0, nblow);
    chk("irq", 1, irq);
    apb(1'b1, OTPFC_IRQ_EN_OFF, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq masked", 0, irq);
    apb(1'b0, OTPFC_IRQ_STAT_OFF, 32'h0);
    chk("irq stat", 32'h2, rd);
    apb(1'b1, OTPFC_IRQ_EN_OFF, 32'h7);
    apb(1'b1, OTPFC_IRQ_CLR_OFF, 32'h7);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 0, irq);
  endtask
  task t_fatal();
    run_unit(8'h02, 6'h15);
    chk("pins", 2'h2, {validation_status_high, validation_status_low});
    chk("lock", 0, fuse_sense[7]);
  endtask
  task t_success();
    run_unit(8'h00, 6'h2D);
    chk("data blows", 4, nblow);
    chk("fuse code", 6'h2D, fuse_sense[6:1]);
    chk("pins", 2'h3, {validation_status_high, validation_status_low});
    apb(1'b0, OTPFC_WIPER_OFF, 32'h0);
    chk("busy write", 32'h2D, rd);
    apb(1'b1, OTPFC_WIPER_OFF, 32'h5);
    apb(1'b1, OTPFC_CTRL_OFF, 32'h1);
    apb(1'b0, OTPFC_WIPER_OFF, 32'h0);
    chk("locked write", 32'h2D, rd);
    apb(1'b0, OTPFC_IRQ_STAT_OFF, 32'h0);
    chk("refused", 1, rd[OTPFC_EV_REFUSED]);
    chk("no reblow", 4, nblow);
    do_reset(1'b0);
    chk("boot tap", 64'h1 << 6'h2D, tap_select);
    chk("boot pins", 2'h3, {validation_status_high, validation_status_low});
    apb(1'b1, OTPFC_CTRL_OFF, 32'h1);
    apb(1'b1, OTPFC_WIPER_OFF, 32'h5);
    apb(1'b0, OTPFC_IRQ_STAT_OFF, 32'h0);
    chk("boot refused", 32'h4, rd);
    apb(1'b0, OTPFC_WIPER_OFF, 32'h0);
    chk("boot wiper", 32'h2D, rd);
    chk("boot no reblow", 4, nblow);
  endtask
  task wrap_up();
    if (errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    wrap_up();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bus_address_select = 1'b1;
    fresh = 1'b0;
    stuck = 8'h00;
    do_reset(1'b1);
    t_boot();
    t_adjust();
    t_testfail();
    t_fatal();
    t_success();
    wrap_up();
  end
endmodule
